// file: rtl/node_status.v
// The AXI4-Lite interface to the registers was chosen for this implementation.
`timescale 1ns/1ps
`include "node_status_defs.vh"
// Contract
// - four flag words per operating level
// - rewrite flag words every cycle while running
// - node n to word (n-1)/16 bit (n-1)%16
// - word four bit 14 is controller error
// - unused level words left as work words
// - refresh transmits own portion to peers
// - automatic tables identical, split 2/4/8/16
// - 918 word limit with older units
// - otherwise at most 2966 linked words
// - oldest host refreshes at most 918 words
// - start by network command or switches
// - start-up node setup word selects mode
// - lamp on linked, flashing error, off
// - two low setup bits per level select area
module node_status #(
   parameter NODES = 62,
   parameter LAMP_HALF = `LAMP_HALF_PERIOD
)(
   input wire aclk,
   input wire aresetn,
   input wire [3:0] s_axi_awaddr_idx_unused,
   input wire [7:0] s_axi_awaddr,
   input wire s_axi_awvalid,
   output wire s_axi_awready,
   input wire [31:0] s_axi_wdata,
   input wire [3:0] s_axi_wstrb,
   input wire s_axi_wvalid,
   output wire s_axi_wready,
   output reg [1:0] s_axi_bresp,
   output reg s_axi_bvalid,
   input wire s_axi_bready,
   input wire [7:0] s_axi_araddr,
   input wire s_axi_arvalid,
   output wire s_axi_arready,
   output reg [31:0] s_axi_rdata,
   output reg [1:0] s_axi_rresp,
   output reg s_axi_rvalid,
   input wire s_axi_rready,
   input wire cycle_tick,
   input wire [NODES-1:0] node_alive,
   input wire cc_error,
   input wire nvm_error,
   input wire net_start,
   input wire switch_start,
   input wire [15:0] remote_setup_word,
   input wire setup_from_remote,
   input wire link_error,
   input wire [11:0] configured_words,
   output reg refresh_send,
   output reg [11:0] refresh_words,
   output reg link_auto,
   output reg [1:0] area_sel_l0,
   output reg [1:0] area_sel_l1,
   output reg link_status_lamp,
   output wire irq
);
   // pins from the network side are resynchronised, except the remote_setup_word bus
   reg [NODES+7:0] sync1_reg;
   reg [NODES+7:0] sync2_reg;
   wire [NODES-1:0] alive_s = sync2_reg[NODES-1:0];
   wire cc_err_s = sync2_reg[NODES];
   wire nvm_err_s = sync2_reg[NODES+1];
   wire net_start_s = sync2_reg[NODES+2];
   wire sw_start_s = sync2_reg[NODES+3];
   wire link_err_s = sync2_reg[NODES+4];
   wire tick_s = sync2_reg[NODES+5];
   wire remote_s = sync2_reg[NODES+6];

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         sync1_reg <= {(NODES+8){1'b0}};
         sync2_reg <= {(NODES+8){1'b0}};
      end
      else
      begin
         sync1_reg <= {1'b0, setup_from_remote, cycle_tick, link_error, switch_start,
                       net_start, nvm_error, cc_error, node_alive};
         sync2_reg <= sync1_reg;
      end
   end

   reg tick_d_reg;
   wire tick_edge = tick_s & ~tick_d_reg;
   reg [15:0] ctrl_reg;
   reg [15:0] setup_reg;
   reg [2:0] irq_status_reg;
   reg [2:0] irq_mask_reg;
   reg running_reg;
   reg [15:0] flags_reg [0:7];
   reg [NODES-1:0] alive_prev_reg;
   wire running_next = running_reg | net_start_s | sw_start_s;

   // flag image: node n sits at word (n-1)/16, bit (n-1)%16
   wire [63:0] image = {nvm_err_s, cc_err_s, alive_s};

   // axi-lite write path: address and data may arrive in either order
   reg aw_hold_reg;
   reg aw_map_reg;
   reg [3:0] aw_idx_reg;
   reg w_hold_reg;
   reg [31:0] wdata_reg;
   assign s_axi_awready = ~aw_hold_reg & ~s_axi_bvalid;
   assign s_axi_wready = ~w_hold_reg & ~s_axi_bvalid;
   wire aw_now = s_axi_awvalid & s_axi_awready;
   wire w_now = s_axi_wvalid & s_axi_wready;
   wire have_aw = aw_hold_reg | aw_now;
   wire have_w = w_hold_reg | w_now;
   wire wr_fire = have_aw & have_w;
   wire [3:0] wr_idx = aw_hold_reg ? aw_idx_reg : s_axi_awaddr[5:2];
   wire [31:0] wr_data = w_hold_reg ? wdata_reg : s_axi_wdata;
   // a held address keeps its own decode, so a late data beat cannot turn an error into okay
   wire wr_map = aw_hold_reg ? aw_map_reg : (s_axi_awaddr[7:6] == 2'b00);
   // unmapped writes are answered but must not alias onto the low indices
   wire wr_ok = wr_fire & wr_map;

   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         aw_map_reg <= 1'b0;
         w_hold_reg <= 1'b0;
         aw_idx_reg <= 4'h0;
         wdata_reg <= 32'h00000000;
         s_axi_bvalid <= 1'b0;
         s_axi_bresp <= 2'b00;
      end
      else
      begin
         if (wr_fire)
         begin
            aw_hold_reg <= 1'b0;
            w_hold_reg <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_map ? 2'b00 : 2'b10;
         end
         else
         begin
            if (aw_now)
            begin
               aw_hold_reg <= 1'b1;
               aw_map_reg <= s_axi_awaddr[7:6] == 2'b00;
               aw_idx_reg <= s_axi_awaddr[7:6] == 2'b00 ? s_axi_awaddr[5:2] : 4'h0;
            end
            if (w_now)
            begin
               w_hold_reg <= 1'b1;
               wdata_reg <= s_axi_wdata;
            end
            if (s_axi_bvalid && s_axi_bready)
               s_axi_bvalid <= 1'b0;
         end
      end
   end

   // flag words refreshed every communications cycle while linked
   genvar gi;
   generate
      for (gi = 0; gi < 8; gi = gi + 1)
      begin : g_flags
         wire lvl_en = ctrl_reg[gi / 4];
         always @(posedge aclk)
         begin
            if (!aresetn)
               flags_reg[gi] <= 16'h0000;
            else if (running_reg && lvl_en && tick_edge)
               flags_reg[gi] <= image[(gi % 4)*16 +: 16];
            else if (!lvl_en && wr_ok && wr_idx == (4'h8 + gi))
               flags_reg[gi] <= wr_data[15:0];
         end
      end
   endgenerate

   // event sources for the sticky status bits
   wire lamp_err = link_err_s & running_reg;
   wire [2:0] irq_set;
   assign irq_set[`IRQ_LINK_UP] = running_next & ~running_reg;
   assign irq_set[`IRQ_LINK_ERR] = lamp_err;
   assign irq_set[`IRQ_NODE_LOST] = tick_edge & running_reg & |(alive_prev_reg & ~alive_s);
   wire [2:0] w1c = (wr_ok && wr_idx == `IDX_IRQ_STATUS) ? wr_data[2:0] : 3'h0;

   // tick edge detector and the previous live set; idle level 0 avoids a false edge
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         tick_d_reg <= 1'b0;
         alive_prev_reg <= {NODES{1'b0}};
      end
      else
      begin
         tick_d_reg <= tick_s;
         if (tick_edge)
            alive_prev_reg <= alive_s;
      end
   end

   // link state is sticky once started; the stop command wins over a held start pin, which restarts the link a cycle later
   wire stop_cmd = wr_ok && wr_idx == `IDX_CTRL && !wr_data[`CTRL_START] &&
                   wr_data[`CTRL_START+8];
   always @(posedge aclk)
   begin
      if (!aresetn)
         running_reg <= 1'b0;
      else
         running_reg <= running_next & ~stop_cmd;
   end

   // control and setup words; a host write to the setup word beats a remote load
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg <= `RST_CTRL;
         setup_reg <= `RST_SETUP;
      end
      else
      begin
         if (wr_ok && wr_idx == `IDX_CTRL)
            ctrl_reg <= wr_data[15:0];
         if (wr_ok && wr_idx == `IDX_SETUP)
            setup_reg <= wr_data[15:0];
         else if (remote_s)
            setup_reg <= remote_setup_word;
      end
   end

   // interrupt mask and sticky status; set wins over write-one-to-clear
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         irq_mask_reg <= `RST_MASK;
         irq_status_reg <= 3'h0;
      end
      else
      begin
         if (wr_ok && wr_idx == `IDX_IRQ_MASK)
            irq_mask_reg <= wr_data[2:0];
         irq_status_reg <= (irq_status_reg & ~w1c) | irq_set;
      end
   end
   // level output: high while any unmasked event is pending
   assign irq = |(irq_status_reg & irq_mask_reg);

   // mode from the setup word; word count from its level 0 mode bits in automatic mode, else configured_words
   wire [1:0] m0 = setup_reg[`SETUP_L0_MODE_LSB +: 2];
   wire [1:0] m1 = setup_reg[`SETUP_L1_MODE_LSB +: 2];
   wire auto_mode = (m0 != `MODE_MANUAL) | (m1 != `MODE_MANUAL);
   wire [11:0] auto_words = (m0[0] ? `AUTO_LR_WORDS : 12'h000) +
                            (m0[1] ? `AUTO_DM_WORDS : 12'h000);
   wire [11:0] want = auto_mode ? auto_words : configured_words;
   wire [11:0] limit = (ctrl_reg[`CTRL_OLD_UNIT] | ctrl_reg[`CTRL_OLD_HOST]) ?
                       `LIMIT_OLD : `LIMIT_NEW;

   // refresh strobe and the word count it carries
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         refresh_send <= 1'b0;
         refresh_words <= 12'h000;
      end
      else
      begin
         refresh_send <= running_reg & tick_edge;
         // clamp rather than refuse: an oversized table still refreshes its first words
         refresh_words <= (want > limit) ? limit : want;
      end
   end

   // table mode and area selection follow the setup word
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         link_auto <= 1'b0;
         area_sel_l0 <= 2'b00;
         area_sel_l1 <= 2'b00;
      end
      else
      begin
         link_auto <= auto_mode;
         area_sel_l0 <= m0;
         area_sel_l1 <= m1;
      end
   end

   // free-running flash timebase; it never pauses, so the flash phase is arbitrary
   reg [31:0] flash_cnt_reg;
   reg flash_reg;
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         flash_cnt_reg <= 32'h00000000;
         flash_reg <= 1'b0;
      end
      else
      begin
         if (flash_cnt_reg >= LAMP_HALF - 1)
         begin
            flash_cnt_reg <= 32'h00000000;
            flash_reg <= ~flash_reg;
         end
         else
            flash_cnt_reg <= flash_cnt_reg + 32'h00000001;
      end
   end

   // link lamp: steady when linked, flashing on error, dark otherwise
   always @(posedge aclk)
   begin
      if (!aresetn)
         link_status_lamp <= 1'b0;
      else
         link_status_lamp <= lamp_err ? flash_reg : running_reg;
   end

   // axi-lite read path, one outstanding read
   reg [31:0] rd_mux;
   assign s_axi_arready = ~s_axi_rvalid;
   always @*
   begin
      rd_mux = 32'h00000000;
      case (s_axi_araddr[5:2])
         `IDX_CTRL: rd_mux = {16'h0000, ctrl_reg};
         `IDX_STAT: rd_mux = {16'h0000, 4'h0, refresh_words[11:0]} |
                             {15'h0000, running_reg, 16'h0000};
         `IDX_IRQ_STATUS: rd_mux = {29'h00000000, irq_status_reg};
         `IDX_IRQ_MASK: rd_mux = {29'h00000000, irq_mask_reg};
         `IDX_WORDS: rd_mux = {20'h00000, want};
         `IDX_SETUP: rd_mux = {16'h0000, setup_reg};
         default: rd_mux = (s_axi_araddr[5] | (s_axi_araddr[5:2] >= 4'h8)) ?
                           {16'h0000, flags_reg[s_axi_araddr[4:2]]} : 32'h00000000;
      endcase
   end

   // read handshake: rvalid stands until rready
   always @(posedge aclk)
   begin
      if (!aresetn)
         s_axi_rvalid <= 1'b0;
      else if (s_axi_arvalid && s_axi_arready)
         s_axi_rvalid <= 1'b1;
      else if (s_axi_rready)
         s_axi_rvalid <= 1'b0;
   end

   // read payload captured with the address, held while rvalid stands
   always @(posedge aclk)
   begin
      if (!aresetn)
      begin
         s_axi_rdata <= 32'h00000000;
         s_axi_rresp <= 2'b00;
      end
      else if (s_axi_arvalid && s_axi_arready)
      begin
         s_axi_rdata <= rd_mux;
         s_axi_rresp <= (s_axi_araddr[7:6] == 2'b00) ? 2'b00 : 2'b10;
      end
   end
endmodule // node_status

// file: rtl/node_status_defs.vh
`ifndef NODE_STATUS_DEFS_VH
`define NODE_STATUS_DEFS_VH
// register indices; byte address is four times the index
`define IDX_L0_W0 4'h8
`define IDX_L0_W1 4'h9
`define IDX_L0_W2 4'hA
`define IDX_L0_W3 4'hB
`define IDX_L1_W0 4'hC
`define IDX_L1_W1 4'hD
`define IDX_L1_W2 4'hE
`define IDX_L1_W3 4'hF
`define IDX_SETUP 4'h7
`define IDX_CTRL 4'h1
`define IDX_STAT 4'h2
`define IDX_IRQ_STATUS 4'h3
`define IDX_IRQ_MASK 4'h4
`define IDX_WORDS 4'h5
// control register fields
`define CTRL_LEVEL0_EN 0
`define CTRL_LEVEL1_EN 1
`define CTRL_START 2
`define CTRL_OLD_UNIT 3
`define CTRL_OLD_HOST 4
// flag positions in the fourth word of each level
`define BIT_CC_ERR 14
`define BIT_NVM_ERR 15
// setup word fields
`define SETUP_L0_MODE_LSB 0
`define SETUP_L1_MODE_LSB 4
`define MODE_MANUAL 2'h0
// word limits
`define LIMIT_OLD 12'h396
`define LIMIT_NEW 12'hB96
`define AUTO_LR_WORDS 12'h040
`define AUTO_DM_WORDS 12'h080
// interrupt bits
`define IRQ_LINK_UP 0
`define IRQ_LINK_ERR 1
`define IRQ_NODE_LOST 2
// reset values
`define RST_CTRL 16'h0000
`define RST_SETUP 16'h0000
`define RST_MASK 3'h0
// lamp flash half period in cycles (250 ms at 100 MHz)
`define LAMP_HALF_PERIOD 25000000
`endif

// file: tb/node_status_chk.sv
`timescale 1ns/1ps
// port-level checks; sees only the top ports
module node_status_chk (
   input wire aclk,
   input wire aresetn,
   input wire s_axi_awvalid,
   input wire s_axi_awready,
   input wire s_axi_wvalid,
   input wire s_axi_wready,
   input wire s_axi_bvalid,
   input wire s_axi_bready,
   input wire s_axi_arvalid,
   input wire s_axi_arready,
   input wire s_axi_rvalid,
   input wire s_axi_rready,
   input wire refresh_send,
   input wire [11:0] refresh_words,
   input wire link_status_lamp,
   input wire irq
);
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // responses stand until taken
   a_bvalid_holds: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
      else $error("bvalid dropped");
   a_rvalid_holds: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid)
      else $error("rvalid dropped");
   a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
      else $error("no read answer");
   a_write_answer: assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid
      && s_axi_wready |=> s_axi_bvalid) else $error("no write answer");
   a_refresh_pulse: assert property (refresh_send |=> !refresh_send)
      else $error("refresh not a pulse");
   a_word_limit: assert property (refresh_send |-> refresh_words <= 12'hB96)
      else $error("too many words");
   a_lamp_half: assert property ($rose(link_status_lamp) |-> link_status_lamp[*4])
      else $error("lamp flash too fast");
   a_out_reset: assert property ($rose(aresetn) |-> !irq && !link_status_lamp)
      else $error("outputs not cleared");
   c_refresh: cover property (refresh_send);
   c_irq: cover property ($rose(irq));
   c_write: cover property (s_axi_bvalid && s_axi_bready);
endmodule // node_status_chk

// file: tb/node_status_tb.sv
`timescale 1ns/1ps
// bench for the node status block
module node_status_tb;
   logic aclk = 0, aresetn = 0, s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
   logic s_axi_arvalid = 0, s_axi_rready = 0, cc_error = 0, nvm_error = 0;
   logic net_start = 0, link_error = 0, run = 0, switch_start = 0, setup_from_remote = 0;
   logic [15:0] remote_setup_word = 0;
   logic [7:0] s_axi_awaddr = 0, s_axi_araddr = 0;
   logic [31:0] s_axi_wdata = 0, rdat;
   logic [61:0] alive_cmd = 0;
   logic [11:0] configured_words = 12'hBB8;
   logic [1:0] rsp;
   wire s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid, cycle_tick;
   wire refresh_send, link_auto, link_status_lamp, irq;
   wire [1:0] s_axi_bresp, s_axi_rresp, area_sel_l0, area_sel_l1;
   wire [31:0] s_axi_rdata;
   wire [61:0] node_alive;
   wire [11:0] refresh_words;
   int n_fail = 0, num_checks = 0, i, k, w;
   // node, flag word index, bit
   int rows[8][3] = '{'{1, 8, 0}, '{16, 8, 15}, '{17, 9, 0}, '{32, 9, 15},
      '{33, 10, 0}, '{48, 10, 15}, '{49, 11, 0}, '{62, 11, 13}};
   node_status #(.LAMP_HALF(4)) i_dut (.s_axi_awaddr_idx_unused(4'h0), .s_axi_wstrb(4'hF), .*);
   peer_nodes i_peer (.*);
   initial forever #5 aclk = ~aclk;
   task automatic ck(input logic [31:0] g, input logic [31:0] e);
      num_checks++;
      if (g !== e)
      begin
         n_fail++;
         $display("mismatch %0t got %h want %h", $time, g, e);
      end
   endtask
   // requests change after a rising edge and stand until the edge that takes them
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic tb;
      @(posedge aclk);
      s_axi_awaddr <= a;
      s_axi_wdata <= d;
      s_axi_awvalid <= 1;
      s_axi_wvalid <= 1;
      s_axi_bready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_awvalid && s_axi_awready) s_axi_awvalid <= 0;
         if (s_axi_wvalid && s_axi_wready) s_axi_wvalid <= 0;
         tb = s_axi_bvalid;
         rsp = s_axi_bresp;
      end while (!tb);
      s_axi_bready <= 0;
   endtask
   task automatic rd(input logic [7:0] a);
      logic v;
      @(posedge aclk);
      s_axi_araddr <= a;
      s_axi_arvalid <= 1;
      s_axi_rready <= 1;
      do
      begin
         @(posedge aclk);
         if (s_axi_arvalid && s_axi_arready) s_axi_arvalid <= 0;
         v = s_axi_rvalid;
         rdat = s_axi_rdata;
         rsp = s_axi_rresp;
      end while (!v);
      s_axi_rready <= 0;
   endtask
   // two refresh pulses: the first may still carry old pin values
   task automatic rf;
      int n;
      repeat (2)
      begin
         n = 0;
         do
         begin
            @(negedge aclk);
            n++;
         end while (refresh_send !== 1 && n < 100);
         if (n >= 100) ck(0, 1);
      end
      @(posedge aclk);
   endtask
   task give_verdict;
      if (n_fail == 0 && num_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   // watchdog well beyond the expected run of under two thousand cycles
   initial
   begin
      #400000;
      n_fail++;
      give_verdict;
   end
   initial
   begin
      repeat (12) @(posedge aclk);
      aresetn <= 1;
      @(negedge aclk);
      ck(irq, 0);
      ck(link_status_lamp, 0);
      rd(8'h04);
      ck(rdat, 0);
      rd(8'h1C);
      ck(rdat, 0);
      wr(8'h10, 4);
      wr(8'h14, 3000);
      wr(8'h04, 3);
      net_start <= 1;
      run <= 1;
      for (i = 0; i < 8; i++)
      begin
         alive_cmd <= 62'h1 << (rows[i][0] - 1);
         rf;
         for (w = 0; w < 8; w++)
         begin
            rd(8'h20 + 4 * w);
            ck(rdat, (w % 4 == rows[i][1] - 8) ? 1 << rows[i][2] : 0);
         end
      end
      @(negedge aclk);
      ck(irq, 1);
      ck(link_status_lamp, 1);
      wr(8'h10, 0);
      @(negedge aclk);
      ck(irq, 0);
      wr(8'h10, 4);
      wr(8'h0C, 4);
      rd(8'h0C);
      ck(rdat & 4, 0);
      ck(irq, 0);
      for (i = 0; i < 2; i++)
      begin
         cc_error <= !i;
         nvm_error <= i;
         rf;
         rd(8'h2C);
         ck(rdat, i ? 32'hA000 : 32'h6000);
      end
      for (i = 0; i < 3; i++)
      begin
         wr(8'h04, i * 8 + 3);
         rf;
         ck(refresh_words, i ? 918 : 2966);
      end
      wr(8'h04, 1);
      wr(8'h30, 32'hA5A5);
      rf;
      rd(8'h30);
      ck(rdat, 32'hA5A5);
      wr(8'h04, 3);
      for (k = 3; k >= 0; k--)
      begin
         wr(8'h1C, k * 17);
         rf;
         ck({link_auto, area_sel_l0, area_sel_l1}, {k != 0, k[1:0], k[1:0]});
      end
      // setup word loaded from the start-up node
      remote_setup_word <= 16'h0012;
      setup_from_remote <= 1;
      rf;
      setup_from_remote <= 0;
      ck({link_auto, area_sel_l0, area_sel_l1}, 5'b11001);
      link_error <= 1;
      w = 0;
      repeat (30)
      begin
         @(negedge aclk);
         w += link_status_lamp;
      end
      ck(w > 0 && w < 30, 1);
      wr(8'h40, 1);
      ck(rsp, 2'h2);
      rd(8'h40);
      ck(rsp, 2'h2);
      // mid-run reset, then a start from the unit switches alone
      link_error <= 0;
      aresetn <= 0;
      net_start <= 0;
      switch_start <= 1;
      repeat (2) @(posedge aclk);
      aresetn <= 1;
      @(negedge aclk);
      ck(link_status_lamp, 0);
      rf;
      @(negedge aclk);
      ck(link_status_lamp, 1);
      give_verdict;
   end
endmodule // node_status_tb
bind node_status node_status_chk i_chk (.*);

// file: tb/peer_nodes.sv
`timescale 1ns/1ps
// far side: cycle tick source and live node set
module peer_nodes (
   input wire aclk,
   input wire run,
   input wire [61:0] alive_cmd,
   output logic cycle_tick = 0,
   output logic [61:0] node_alive = 0
);
   int cnt = 0;
   // tick every 20 cycles, held 6 so the pin sync cannot miss it
   always @(posedge aclk)
   begin
      cnt <= (cnt == 19) ? 0 : cnt + 1;
      cycle_tick <= run && (cnt < 6);
      node_alive <= alive_cmd;
   end
endmodule // peer_nodes
